/* bench/dcr_ctl_model.sv */
// Purpose: memory controller model driving the command pins
// Assumes: commands change just after a rising clk_i edge
// Notes: power-up pause is shortened by PAUSE_CYC
`timescale 1ns/10ps
module dcr_ctl_model #(
  parameter int PAUSE_CYC = 4 // shortened stable-clock pause
) (
  input wire logic clk_i,
  output logic cke_o,
  output dcr_pkg::dcr_cmd_bus_t cmd_o
);
  // idle: selected nop, clock enable low until power-up
  initial
  begin
    cke_o = 1'b0;
    cmd_o = {1'b0, dcr_pkg::DCR_CMD_NOP, 3'h0, 11'h000};
  end
  // one command for exactly one edge, then nop
  task automatic send(input logic cs_n, input dcr_pkg::dcr_cmd_t c, input logic [2:0] b,
    input logic [10:0] a);
    @(posedge clk_i);
    cmd_o <= {cs_n, c, b, a};
    @(posedge clk_i);
    cmd_o <= {1'b0, dcr_pkg::DCR_CMD_NOP, 3'h0, 11'h000};
  endtask
  // clock enable held low stays low through self-refresh
  task automatic set_cke(input logic v);
    @(posedge clk_i);
    cke_o <= v;
  endtask
  // power-up order; final mode gives 8 beats, latency 2
  task automatic power_up;
    repeat (PAUSE_CYC) @(posedge clk_i);
    set_cke(1'b1);
    send(1'b0, dcr_pkg::DCR_CMD_PRECHARGE, 3'h0, 11'h400);
    repeat (3) @(posedge clk_i);
    send(1'b0, dcr_pkg::DCR_CMD_MODE, 3'h1, 11'h000);
    send(1'b0, dcr_pkg::DCR_CMD_MODE, 3'h0, 11'h123);
    send(1'b0, dcr_pkg::DCR_CMD_REFRESH, 3'h0, 11'h000);
    send(1'b0, dcr_pkg::DCR_CMD_REFRESH, 3'h0, 11'h000);
    send(1'b0, dcr_pkg::DCR_CMD_MODE, 3'h0, 11'h023);
  endtask
endmodule

/* bench/dcr_device_chk.sv */
// Purpose: port-level assertions for the command block
// Assumes: single clock domain, sync reset
// Notes: burst length unknown here, so halt uses a bound
`timescale 1ns/10ps
module dcr_device_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire dcr_pkg::dcr_cmd_bus_t cmd_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic dq_oe_o,
  input wire logic dqs_oe_o,
  input wire logic [6:0] col_o,
  input wire logic self_refresh_o,
  input wire logic init_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // command accepted on the pins this edge
  wire logic tk = !cmd_i.cs_n && !self_refresh_o;
  wire logic [2:0] op = {cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n};
  wire logic rd = tk && op == dcr_pkg::DCR_CMD_READ;
  a_strobe_pair: assert property (dq_oe_o == dqs_oe_o) else $error("strobe split");
  a_read_start: assert property (rd && init_done_o |=> dq_oe_o && col_o == $past(cmd_i.addr[6:0]))
    else $error("burst start wrong");
  a_early_read: assert property (rd && !init_done_o |=> !dq_oe_o) else $error("early read");
  a_halt_float: assert property (tk && op == dcr_pkg::DCR_CMD_HALT && dq_oe_o |-> ##[1:8] !dq_oe_o)
    else $error("halt no float");
  a_self_entry: assert property (tk && op == dcr_pkg::DCR_CMD_REFRESH && !cke_i && init_done_o
    |=> self_refresh_o) else $error("no self entry");
  a_self_stay: assert property (self_refresh_o && !cke_i |=> self_refresh_o)
    else $error("left self early");
  a_self_float: assert property (self_refresh_o |-> !dq_oe_o) else $error("self drives");
  a_self_exit: assert property (self_refresh_o && cke_i ##1 cke_i |-> ##[1:2] !self_refresh_o)
    else $error("no self exit");
  a_done_hold: assert property (init_done_o |=> init_done_o) else $error("init lost");
  a_wb_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
    |=> wb_ack_o || wb_err_o) else $error("no bus answer");
  c_read: cover property (rd && init_done_o);
  c_self: cover property ($rose(self_refresh_o));
  c_halt: cover property (tk && op == dcr_pkg::DCR_CMD_HALT && dq_oe_o);
endmodule
bind dcr_device dcr_device_chk u_chk (.clk_i, .rst_i, .cke_i, .cmd_i, .wb_cyc_i, .wb_stb_i,
  .wb_ack_o, .wb_err_o, .dq_oe_o, .dqs_oe_o, .col_o, .self_refresh_o, .init_done_o);

/* bench/ddr_dram_cmd_refresh_init_test.sv */
// Purpose: directed bench for the command, refresh and init block
// Assumes: 10 MHz clock, reset held five cycles
// Notes: pin outputs sampled on the falling edge, after updates land; wishbone answers on the rising edge
`timescale 1ns/10ps
module ddr_dram_cmd_refresh_init_test;
  logic clk_i, rst_i, cke, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wb_err_o, er;
  logic dq_oe_o, dqs_oe_o, self_refresh_o, init_done_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd, r0;
  logic [6:0] col_o;
  dcr_pkg::dcr_cmd_bus_t cmd;
  int errors, checks;
  dcr_ctl_model u_ctl (.clk_i(clk_i), .cke_o(cke), .cmd_o(cmd));
  dcr_device u_dut (.clk_i(clk_i), .rst_i(rst_i), .cke_i(cke), .cmd_i(cmd),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(4'hF), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .dq_oe_o(dq_oe_o), .dqs_oe_o(dqs_oe_o), .col_o(col_o),
    .self_refresh_o(self_refresh_o), .init_done_o(init_done_o));
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic finish_test;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // classic single cycle; request held until ack or err is sampled
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {24'h0, a};
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (!(wb_ack_o === 1'b1 || wb_err_o === 1'b1) && n < 20);
    q = wb_dat_o;
    e = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 20)
    begin
      errors++;
      finish_test();
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0, rd, er);
    chk({rd[31:1], er}, {exp[31:1], 1'b0} | {31'h0, exp[0] & 1'b0});
    chk(rd, exp);
  endtask
  // eight-beat burst: low three column bits step and wrap
  task automatic burst(input logic [6:0] s);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge clk_i);
      chk({30'h0, dq_oe_o, dqs_oe_o}, 32'h3);
      chk({25'h0, col_o}, {25'h0, s[6:3], s[2:0] + i[2:0]});
    end
    @(negedge clk_i);
    chk({30'h0, dq_oe_o, dqs_oe_o}, 32'h0);
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  initial
  begin
    errors = 0;
    checks = 0;
    rst_i = 1'b1;
    {wb_we_i, wb_cyc_i, wb_stb_i} = 3'h0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk({29'h0, init_done_o, self_refresh_o, dq_oe_o}, 32'h0);
    rchk(dcr_pkg::REG_STATUS, 32'h0);
    wb(1'b0, 8'h40, 32'h0, rd, er);
    chk({31'h0, er}, 32'h1);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_READ, 3'h0, 11'h000);
    wait_n(2);
    chk({31'h0, dq_oe_o}, 32'h0);
    rchk(dcr_pkg::REG_REJECT, 32'h1);
    $display("test reset_reject done");
    u_ctl.power_up();
    wait_n(2);
    chk({31'h0, init_done_o}, 32'h1);
    rchk(dcr_pkg::REG_MODE, 32'h23);
    wb(1'b1, dcr_pkg::REG_MODE, 32'h45, rd, er);
    rchk(dcr_pkg::REG_MODE, 32'h23);
    $display("test init done");
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_ACTIVATE, 3'h1, 11'h010);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_READ, 3'h1, 11'h003);
    fork
      burst(7'h03);
      u_ctl.send(1'b1, dcr_pkg::DCR_CMD_READ, 3'h1, 11'h005);
    join
    $display("test burst done");
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_ACTIVATE, 3'h2, 11'h020);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_READ, 3'h2, 11'h000);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_HALT, 3'h2, 11'h000);
    wait_n(3);
    chk({31'h0, dq_oe_o}, 32'h0);
    rchk(dcr_pkg::REG_STATUS, 32'h061);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_PRECHARGE, 3'h2, 11'h000);
    wait_n(4);
    rchk(dcr_pkg::REG_STATUS, 32'h021);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_ACTIVATE, 3'h4, 11'h040);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_PRECHARGE, 3'h0, 11'h400);
    wait_n(4);
    rchk(dcr_pkg::REG_STATUS, 32'h001);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_ACTIVATE, 3'h3, 11'h030);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_READ, 3'h3, 11'h406);
    burst(7'h06);
    wait_n(4);
    rchk(dcr_pkg::REG_STATUS, 32'h001);
    $display("test precharge done");
    wb(1'b0, dcr_pkg::REG_REFROW, 32'h0, r0, er);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_REFRESH, 3'h0, 11'h000);
    wait_n(10);
    rchk(dcr_pkg::REG_REFROW, r0 + 32'h1);
    u_ctl.set_cke(1'b0);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_REFRESH, 3'h0, 11'h000);
    wait_n(2);
    chk({31'h0, self_refresh_o}, 32'h1);
    u_ctl.send(1'b0, dcr_pkg::DCR_CMD_READ, 3'h0, 11'h000);
    wait_n(3);
    chk({31'h0, dq_oe_o}, 32'h0);
    rchk(dcr_pkg::REG_STATUS, 32'h003);
    u_ctl.set_cke(1'b1);
    wait_n(3);
    chk({31'h0, self_refresh_o}, 32'h0);
    $display("test refresh done");
    finish_test();
  end
endmodule

/* hdl/dcr_burst_ctr.sv */
// Purpose: column counter for one burst with sequential wrap
// Assumes: burst length of 2, 4 or 8 encoded as 1, 2, 3
// Notes: only the low bits inside the boundary step, upper bits stay
`timescale 1ns/10ps
module dcr_burst_ctr #(
  parameter int COL_W = 7
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic step_i,
  input wire logic [COL_W-1:0] start_i,
  input wire logic [2:0] bl_i,
  output logic [COL_W-1:0] col_o
);
  initial if (COL_W < 3) $error("column width must be at least 3");
  logic [COL_W-1:0] col_q, col_d;
  logic [COL_W-1:0] mask; // bits that wrap
  logic [COL_W-1:0] inc;
  // next column, wrapping inside the boundary
  always_comb
  begin
    unique case (bl_i)
      3'h1: mask = COL_W'(3'h1);
      3'h2: mask = COL_W'(3'h3);
      default: mask = COL_W'(3'h7);
    endcase
    inc = col_q + COL_W'(1);
    col_d = col_q;
    if (load_i)
    begin
      col_d = start_i;
    end
    else if (step_i)
    begin
      col_d = (col_q & ~mask) | (inc & mask);
    end
  end
  // register only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      col_q <= '0;
    else
      col_q <= col_d;
  end
  assign col_o = col_q;
endmodule

/* hdl/dcr_device.sv */
// Purpose: command decode, bank state, refresh, self-refresh and init tracking
// Assumes: inputs synchronous to clk_i; wishbone classic slave for software
// Notes: data path is modelled by strobes only; one data beat per clock
`timescale 1ns/10ps
// How it works
// - burst column steps by one, wrapping
// - chip select high ignores commands, bursts continue
// - halt floats read outputs after cas latency on reads without autoclose
// - precharge all line closes every bank
// - banks become idle after precharge wait
// - line high on access gives autoclose
// - refresh uses internal row counter
// - refresh with cke low enters self-refresh
// - self-refresh floats outputs, ignores commands
// - mode register holds four address fields
// - mode values kept until reprogrammed
module dcr_device #(
  parameter int BANKS = 8,
  parameter int ROW_W = 11
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cke_i,
  input wire dcr_pkg::dcr_cmd_bus_t cmd_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic dq_oe_o,
  output logic dqs_oe_o,
  output logic [6:0] col_o,
  output logic self_refresh_o,
  output logic init_done_o
);
  initial if (BANKS != 8 || ROW_W > 16) $error("unsupported geometry");
  localparam logic [2:0] PW_CYC = 3'(dcr_pkg::PRECHARGE_WAIT_CYC);
  localparam logic [9:0] ST_CYC = 10'(dcr_pkg::SELF_TICK_CYC);

  dcr_pkg::dcr_cmd_t cmd;
  logic sel; // command is live this cycle
  logic all_bank_close_cmd;
  assign cmd = dcr_pkg::dcr_cmd_t'({cmd_i.ras_n, cmd_i.cas_n, cmd_i.we_n});
  assign all_bank_close_cmd = cmd_i.addr[10];

  // state registers
  dcr_pkg::dcr_pw_t pw_q, pw_d;
  dcr_pkg::dcr_init_t init_q, init_d;
  dcr_pkg::dcr_mode_t mode_q, mode_d;
  logic [BANKS-1:0] open_q, open_d; // bank holds an active row
  logic [BANKS-1:0] closing_q, closing_d; // precharge in flight
  logic [2:0] pwait_q [BANKS]; // precharge countdown per bank
  logic [2:0] pwait_d [BANKS];
  logic [ROW_W-1:0] refrow_q, refrow_d; // internal refresh row
  logic [9:0] stick_q, stick_d; // self-refresh timer
  logic [1:0] exitc_q, exitc_d; // cke high count on exit
  logic [3:0] beats_q, beats_d; // remaining burst beats
  logic rd_q, rd_d; // burst is a read
  logic ac_q, ac_d; // burst closes its bank
  logic [2:0] bb_q, bb_d; // burst bank
  logic [2:0] halt_q, halt_d; // latency countdown to float
  logic [15:0] rej_q, rej_d; // rejected accesses
  logic [1:0] nref_q, nref_d; // refreshes seen during init
  logic oe_q, oe_d;
  logic self_q; // registered self-refresh flag for the pin
  logic done_q; // registered init-complete flag for the pin
  logic start, step;
  // cs high or self-refresh makes the command bus a don't-care
  assign sel = !cmd_i.cs_n && pw_q == dcr_pkg::DCR_PW_NORMAL;

  // command decode, bank, burst, refresh and init next state
  always_comb
  begin
    pw_d = pw_q;
    init_d = init_q;
    mode_d = mode_q;
    open_d = open_q;
    closing_d = closing_q;
    pwait_d = pwait_q;
    refrow_d = refrow_q;
    stick_d = stick_q;
    exitc_d = exitc_q;
    beats_d = beats_q;
    rd_d = rd_q;
    ac_d = ac_q;
    bb_d = bb_q;
    halt_d = halt_q;
    rej_d = rej_q;
    nref_d = nref_q;
    start = 1'b0;
    step = 1'b0;
    // precharge timers; bank idles when the wait runs out
    for (int b = 0; b < BANKS; b++)
    begin
      if (closing_q[b])
      begin
        if (pwait_q[b] <= 3'h1)
        begin
          closing_d[b] = 1'b0;
        end
        pwait_d[b] = pwait_q[b] - 3'h1;
      end
    end
    // running burst keeps going regardless of cs
    if (beats_q != 4'h0)
    begin
      step = 1'b1;
      beats_d = beats_q - 4'h1;
      if (beats_q == 4'h1 && ac_q)
      begin
        open_d[bb_q] = 1'b0;
        closing_d[bb_q] = 1'b1;
        pwait_d[bb_q] = PW_CYC;
      end
    end
    if (halt_q != 3'h0)
    begin
      halt_d = halt_q - 3'h1;
    end
    if (sel)
    begin
      unique case (cmd)
        dcr_pkg::DCR_CMD_MODE:
        begin
          if (cmd_i.bank[0])
          begin
            // extended mode; loop_on_bit low enables the loop
            if (init_q == dcr_pkg::DCR_INIT_EXT && !cmd_i.addr[dcr_pkg::LOOP_ON_BIT])
              init_d = dcr_pkg::DCR_INIT_LOOPRST;
          end
          else
          begin
            mode_d = cmd_i.addr[7:0];
            if (init_q == dcr_pkg::DCR_INIT_LOOPRST &&
                !cmd_i.addr[dcr_pkg::LOOP_RESTART_BIT] && nref_q == 2'h2)
              init_d = dcr_pkg::DCR_INIT_DONE;
          end
        end
        dcr_pkg::DCR_CMD_REFRESH:
        begin
          refrow_d = refrow_q + ROW_W'(1);
          if (nref_q != 2'h2)
            nref_d = nref_q + 2'h1;
          if (!cke_i)
          begin
            pw_d = dcr_pkg::DCR_PW_SELF;
            stick_d = '0;
          end
        end
        dcr_pkg::DCR_CMD_PRECHARGE:
        begin
          if (all_bank_close_cmd)
          begin
            closing_d = closing_d | open_q;
            open_d = '0;
            for (int b = 0; b < BANKS; b++)
              pwait_d[b] = PW_CYC;
            if (init_q == dcr_pkg::DCR_INIT_PRECH)
              init_d = dcr_pkg::DCR_INIT_EXT;
          end
          else
          begin
            open_d[cmd_i.bank] = 1'b0;
            // keep a close already in flight, do not cut its wait short
            closing_d[cmd_i.bank] = closing_d[cmd_i.bank] | open_q[cmd_i.bank];
            pwait_d[cmd_i.bank] = PW_CYC;
          end
        end
        dcr_pkg::DCR_CMD_ACTIVATE:
        begin
          open_d[cmd_i.bank] = 1'b1;
        end
        dcr_pkg::DCR_CMD_READ, dcr_pkg::DCR_CMD_STORE:
        begin
          if (init_q != dcr_pkg::DCR_INIT_DONE)
          begin
            rej_d = rej_q + 16'h1;
          end
          else
          begin
            start = 1'b1;
            beats_d = 4'(1 << mode_q.burst_len);
            rd_d = cmd == dcr_pkg::DCR_CMD_READ;
            ac_d = all_bank_close_cmd;
            bb_d = cmd_i.bank;
            halt_d = 3'h0;
          end
        end
        dcr_pkg::DCR_CMD_HALT:
        begin
          if (rd_q && !ac_q && beats_q != 4'h0)
          begin
            halt_d = mode_q.cas_lat;
          end
        end
        default:
        begin
        end
      endcase
    end
    // init waits for cke high, whatever the command
    if (init_q == dcr_pkg::DCR_INIT_WAIT_CKE && cke_i)
      init_d = dcr_pkg::DCR_INIT_PRECH;
    // self-refresh: internal timer refreshes rows
    if (pw_q == dcr_pkg::DCR_PW_SELF)
    begin
      stick_d = stick_q + 10'h1;
      if (stick_q == ST_CYC - 10'h1)
      begin
        stick_d = '0;
        refrow_d = refrow_q + ROW_W'(1);
      end
      exitc_d = '0;
      if (cke_i)
      begin
        pw_d = dcr_pkg::DCR_PW_EXIT;
        exitc_d = 2'h1;
      end
    end
    else if (pw_q == dcr_pkg::DCR_PW_EXIT)
    begin
      if (!cke_i)
        pw_d = dcr_pkg::DCR_PW_SELF;
      else if (exitc_q == 2'(dcr_pkg::EXIT_HOLD_CYC - 1))
        pw_d = dcr_pkg::DCR_PW_NORMAL;
      else
        exitc_d = exitc_q + 2'h1;
    end
    // read drives until burst ends or halt latency expires
    oe_d = rd_d && beats_d != 4'h0 && pw_d == dcr_pkg::DCR_PW_NORMAL;
    if (halt_q == 3'h1)
    begin
      oe_d = 1'b0;
      beats_d = '0;
    end
  end

  // state register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pw_q <= dcr_pkg::DCR_PW_NORMAL;
      init_q <= dcr_pkg::DCR_INIT_WAIT_CKE;
      mode_q <= {1'b0, dcr_pkg::CL_RESET, 1'b0, dcr_pkg::BL_RESET};
      open_q <= '0;
      closing_q <= '0;
      for (int b = 0; b < BANKS; b++)
        pwait_q[b] <= '0;
      refrow_q <= '0;
      stick_q <= '0;
      exitc_q <= '0;
      beats_q <= '0;
      rd_q <= 1'b0;
      ac_q <= 1'b0;
      bb_q <= '0;
      halt_q <= '0;
      rej_q <= '0;
      nref_q <= '0;
      oe_q <= 1'b0;
      self_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      pw_q <= pw_d;
      init_q <= init_d;
      mode_q <= mode_d;
      open_q <= open_d;
      closing_q <= closing_d;
      pwait_q <= pwait_d;
      refrow_q <= refrow_d;
      stick_q <= stick_d;
      exitc_q <= exitc_d;
      beats_q <= beats_d;
      rd_q <= rd_d;
      ac_q <= ac_d;
      bb_q <= bb_d;
      halt_q <= halt_d;
      rej_q <= rej_d;
      nref_q <= nref_d;
      oe_q <= oe_d;
      self_q <= pw_d != dcr_pkg::DCR_PW_NORMAL;
      done_q <= init_d == dcr_pkg::DCR_INIT_DONE;
    end
  end

  dcr_burst_ctr #(.COL_W(7)) u_ctr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(start),
    .step_i(step && !start),
    .start_i(cmd_i.addr[6:0]),
    .bl_i(mode_q.burst_len),
    .col_o(col_o)
  );

  // wishbone slave: ack one cycle after request, drops next cycle
  logic ack_q, err_q;
  logic [31:0] dat_q, dat_d;
  logic hit;
  always_comb
  begin
    hit = 1'b1;
    dat_d = '0;
    unique case (wb_adr_i[7:0])
      dcr_pkg::REG_CTRL: dat_d = 32'h0;
      dcr_pkg::REG_STATUS: dat_d = {20'h0, open_q, 1'b0, oe_q,
                                    pw_q != dcr_pkg::DCR_PW_NORMAL,
                                    init_q == dcr_pkg::DCR_INIT_DONE};
      dcr_pkg::REG_MODE: dat_d = {24'h0, mode_q};
      dcr_pkg::REG_REFROW: dat_d = 32'(refrow_q);
      dcr_pkg::REG_REJECT: dat_d = {16'h0, rej_q};
      default: hit = 1'b0;
    endcase
  end
  // register answers; ctrl write 1 in bit 0 is accepted and has no state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q && !err_q && hit;
      err_q <= wb_cyc_i && wb_stb_i && !ack_q && !err_q && !hit;
      dat_q <= (wb_cyc_i && wb_stb_i && !wb_we_i) ? dat_d : 32'h0;
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign wb_dat_o = dat_q;
  assign dq_oe_o = oe_q;
  assign dqs_oe_o = oe_q;
  assign self_refresh_o = self_q;
  assign init_done_o = done_q;
endmodule

/* pkg/dcr_pkg.sv */
// Purpose: shared constants and types for the ddr command, refresh and init block
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes: register offsets are word-aligned byte addresses on classic wishbone
package dcr_pkg;
  // clock rate and derived counts
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned PRECHARGE_WAIT_NS = 300; // precharge interval
  localparam int unsigned PRECHARGE_WAIT_CYC =
    (PRECHARGE_WAIT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SELF_TICK_NS = 8000; // internal self-refresh period
  localparam int unsigned SELF_TICK_CYC = SELF_TICK_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int unsigned EXIT_HOLD_CYC = 2; // cke high cycles to leave self-refresh
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MODE = 8'h08;
  localparam logic [7:0] REG_REFROW = 8'h0C;
  localparam logic [7:0] REG_REJECT = 8'h10;
  // mode register field positions on the address lines
  localparam int unsigned MODE_BL_LSB = 0;
  localparam int unsigned MODE_BT_BIT = 3;
  localparam int unsigned MODE_CL_LSB = 4;
  localparam int unsigned MODE_TEST_BIT = 7;
  localparam int unsigned LOOP_RESTART_BIT = 8;
  localparam int unsigned LOOP_ON_BIT = 0;
  localparam logic [2:0] BL_RESET = 3'h1;
  localparam logic [2:0] CL_RESET = 3'h2;
  // command encoding {ras_n, cas_n, we_n}
  typedef enum logic [2:0] {
    DCR_CMD_MODE = 3'h0, DCR_CMD_REFRESH = 3'h1, DCR_CMD_PRECHARGE = 3'h2,
    DCR_CMD_ACTIVATE = 3'h3, DCR_CMD_STORE = 3'h4, DCR_CMD_READ = 3'h5,
    DCR_CMD_HALT = 3'h6, DCR_CMD_NOP = 3'h7
  } dcr_cmd_t;
  // command bus as seen on the device pins
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [2:0] bank;
    logic [10:0] addr; // addr[10] doubles as the precharge_all_line
  } dcr_cmd_bus_t;
  // programmed mode fields
  typedef struct packed {
    logic test_entry;
    logic [2:0] cas_lat;
    logic burst_type;
    logic [2:0] burst_len;
  } dcr_mode_t;
  // init progress
  typedef enum logic [2:0] {
    DCR_INIT_WAIT_CKE, DCR_INIT_PRECH, DCR_INIT_EXT, DCR_INIT_LOOPRST, DCR_INIT_DONE
  } dcr_init_t;
  typedef enum logic [1:0] {DCR_PW_NORMAL, DCR_PW_SELF, DCR_PW_EXIT} dcr_pw_t;
endpackage
